/* design/dbfa_adapter.sv */
`timescale 1ns/100ps
`default_nettype none
// How it works
// - controller maps flash as 11x10 bank three
// - row bit 8 carries flash bank select
// - controller uses cas-before-ras refresh, fast mode
// - only processor cycles reach the flash
// - only full 32-bit accesses are honoured
// - reads return flash data, writes pass commands
// - software programs flash with standard command writes
// - software keeps flash writes out of caches
// - never two flash writes back to back
// - other bank access before and after writes
// - reads work single or burst, unrestricted
// - four byte-mode devices form each bank
// - cpu dword bit drives flash a0
// - software scales flash offsets by four
// - bank bases follow installed dram size
// - flash looks like one 32-bit edo bank
module dbfa_adapter (
   input  wire logic                                 clock,
   input  wire logic                                 reset_n,
   dbfa_if.adapter                                   dram,
   output logic [1:0]                                flash_ce_n,
   output logic                                      flash_oe_n,
   output logic                                      flash_we_n,
   output logic [dbfa_pkg::FLASH_ADDR_BITS-1:0]      flash_addr,
   input  wire logic [dbfa_pkg::DATA_BITS-1:0]       flash_dq_in,
   output logic [dbfa_pkg::DATA_BITS-1:0]            flash_dq_out,
   output logic                                      flash_dq_oe_n,
   output logic                                      access_ignored
);

   dbfa_pkg::dbfa_astate_e                  state_q;
   logic                                    ras_prev_q;
   logic                                    cas_idle_q;
   logic                                    refresh_q;
   logic [dbfa_pkg::ROW_BITS-1:0]           row_q;
   logic [dbfa_pkg::CNT_W-1:0]              cnt_q;
   logic [dbfa_pkg::DATA_BITS-1:0]          rdata_q;
   logic                                    rdata_oe_n_q;

   // edge detection on the strobes; both ends share one clock, so no synchroniser
   wire cas_any  = (dram.cas_n != {dbfa_pkg::LANES{1'b1}});
   wire cas_all  = (dram.cas_n == {dbfa_pkg::LANES{1'b0}});
   wire ras_fall = !dram.ras_n && ras_prev_q;
   wire cbr_seen = ras_fall && cas_any;
   wire cas_fall = cas_any && cas_idle_q && !dram.ras_n && !refresh_q;
   // bus-master and partial accesses are dropped: the flash has no byte lanes of its own
   wire take_ok  = cas_fall && dram.cpu_cycle && cas_all;
   wire take_bad = cas_fall && !take_ok;
   wire bank_sel = row_q[dbfa_pkg::BANK_SEL_BIT];
   // column bit 0 is cpu dword bit, so flash a0 steps per dword
   wire [dbfa_pkg::FLASH_ADDR_BITS-1:0] fa_next =
      dbfa_pkg::dbfa_flash_of(row_q, dram.addr[dbfa_pkg::COL_BITS-1:0]);
   wire [1:0] ce_next = bank_sel ? 2'h1 : 2'h2;
   wire acc_end = (cnt_q == dbfa_pkg::CNT_W'(dbfa_pkg::FLASH_ACC_CYC - 1));
   wire we_end  = (cnt_q == dbfa_pkg::CNT_W'(dbfa_pkg::FLASH_WE_CYC - 1));

   assign dram.rdata      = rdata_q;
   assign dram.rdata_oe_n = rdata_oe_n_q;

   // strobe history and row capture; a cbr refresh row is never latched
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ras_prev_q <= 1'b1;
         cas_idle_q <= 1'b1;
         refresh_q  <= 1'b0;
         row_q      <= '0;
      end
      else
      begin
         ras_prev_q <= dram.ras_n;
         cas_idle_q <= !cas_any;
         if (dram.ras_n)
            refresh_q <= 1'b0;
         else if (cbr_seen)
            refresh_q <= 1'b1;
         if (ras_fall && !cas_any)
            row_q <= dram.addr;
      end
   end

   // access sequencer: each cas fall inside one ras is a new beat, so bursts
   // and single beats read alike; the flash keeps no write data of its own
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q        <= dbfa_pkg::A_IDLE;
         cnt_q          <= '0;
         flash_ce_n     <= 2'h3;
         flash_oe_n     <= 1'b1;
         flash_we_n     <= 1'b1;
         flash_addr     <= '0;
         flash_dq_out   <= '0;
         flash_dq_oe_n  <= 1'b1;
         rdata_q        <= '0;
         rdata_oe_n_q   <= 1'b1;
         access_ignored <= 1'b0;
      end
      else
      begin
         access_ignored <= take_bad;
         case (state_q)
            dbfa_pkg::A_IDLE:
            begin
               if (take_ok)
               begin
                  cnt_q      <= '0;
                  flash_addr <= fa_next;
                  flash_ce_n <= ce_next;
                  if (dram.we_n)
                  begin
                     flash_oe_n <= 1'b0;
                     state_q    <= dbfa_pkg::A_READ;
                  end
                  else
                  begin
                     // command cycle only: data goes to the devices' decoders
                     flash_we_n    <= 1'b0;
                     flash_dq_out  <= dram.wdata;
                     flash_dq_oe_n <= 1'b0;
                     state_q       <= dbfa_pkg::A_WRITE;
                  end
               end
            end
            dbfa_pkg::A_READ:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (acc_end)
               begin
                  rdata_q      <= flash_dq_in;
                  rdata_oe_n_q <= 1'b0;
                  flash_oe_n   <= 1'b1;
                  flash_ce_n   <= 2'h3;
                  state_q      <= dbfa_pkg::A_HOLD;
               end
               else if (dram.ras_n)
               begin
                  flash_oe_n <= 1'b1;
                  flash_ce_n <= 2'h3;
                  state_q    <= dbfa_pkg::A_IDLE;
               end
            end
            dbfa_pkg::A_WRITE:
            begin
               cnt_q <= cnt_q + 1'b1;
               // the we pulse runs its full width even if cas rises early
               if (we_end)
               begin
                  flash_we_n    <= 1'b1;
                  flash_dq_oe_n <= 1'b1;
                  flash_ce_n    <= 2'h3;
                  state_q       <= dbfa_pkg::A_HOLD;
               end
            end
            dbfa_pkg::A_HOLD:
            begin
               // edo style: read data stays until cas rises
               if (!cas_any)
               begin
                  rdata_oe_n_q <= 1'b1;
                  state_q      <= dbfa_pkg::A_IDLE;
               end
            end
            default:
            begin
               state_q <= dbfa_pkg::A_IDLE;
            end
         endcase
      end
   end

endmodule : dbfa_adapter
`default_nettype wire

/* design/dbfa_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// dram controller end: one command at a time, cbr refresh, flash write guard
module dbfa_ctrl #(
   parameter int REFRESH_CYC = dbfa_pkg::REFRESH_CYC
) (
   input  wire logic                  clock,
   input  wire logic                  reset_n,
   dbfa_if.ctrl                       dram,
   input  wire logic [4:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [31:0]                reg_rdata
);

   dbfa_pkg::dbfa_hstate_e                  state_q;
   logic [31:0]                             addr_q;
   logic [31:0]                             wdata_q;
   logic [31:0]                             cmd_q;
   logic [31:0]                             rdata_q;
   logic                                    start_q;
   logic                                    done_q;
   logic                                    refused_q;
   logic                                    last_flash_wr_q;
   logic [dbfa_pkg::REF_W-1:0]              ref_cnt_q;
   logic                                    ref_pend_q;
   logic [dbfa_pkg::CNT_W-1:0]              cnt_q;
   logic                                    ras_n_q;
   logic [dbfa_pkg::LANES-1:0]              cas_n_q;
   logic                                    we_n_q;
   logic [dbfa_pkg::ROW_BITS-1:0]           addr_bus_q;
   logic [dbfa_pkg::DATA_BITS-1:0]          wdata_bus_q;
   logic                                    cpu_q;
   logic [31:0]                             status_word;

   // address decode: flash space sits right above dram banks zero to two
   wire [31:0] off       = addr_q - dbfa_pkg::FLASH_BANK0_BASE;
   wire        in_flash  = (addr_q >= dbfa_pkg::FLASH_BANK0_BASE) && (off < dbfa_pkg::FLASH_SPACE_SIZE);
   wire        is_write  = cmd_q[dbfa_pkg::CMD_WRITE_BIT];
   // a flash write straight after a flash write is refused, the devices would miss it
   wire        guard_hit = in_flash && is_write && last_flash_wr_q;
   wire [dbfa_pkg::ROW_BITS-1:0] row_addr = dbfa_pkg::dbfa_row_of(off);
   wire [dbfa_pkg::ROW_BITS-1:0] col_addr = {1'b0, off[dbfa_pkg::DWORD_CPU_BIT +: dbfa_pkg::COL_BITS]};
   wire [dbfa_pkg::LANES-1:0]    be       = cmd_q[dbfa_pkg::CMD_BE_LSB +: dbfa_pkg::LANES];
   wire        cmd_wr    = reg_wr && (reg_addr == dbfa_pkg::REG_CMD);
   wire        busy      = start_q || (state_q != dbfa_pkg::H_IDLE);
   wire        ref_hit   = (ref_cnt_q == dbfa_pkg::REF_W'(REFRESH_CYC - 1));
   wire        ref_go    = (state_q == dbfa_pkg::H_IDLE) && ref_pend_q;
   wire        hold_end  = (cnt_q == dbfa_pkg::CNT_W'(dbfa_pkg::CAS_HOLD_CYC - 1));
   wire        pre_end   = (cnt_q == dbfa_pkg::CNT_W'(dbfa_pkg::PRECHARGE_CYC - 1));
   wire        rfr_end   = (cnt_q == dbfa_pkg::CNT_W'(dbfa_pkg::REF_RAS_CYC - 1));

   assign dram.ras_n     = ras_n_q;
   assign dram.cas_n     = cas_n_q;
   assign dram.we_n      = we_n_q;
   assign dram.addr      = addr_bus_q;
   assign dram.wdata     = wdata_bus_q;
   assign dram.cpu_cycle = cpu_q;

   // status word assembled from the flag positions
   always_comb
   begin
      status_word = '0;
      status_word[dbfa_pkg::STAT_BUSY_BIT]    = busy;
      status_word[dbfa_pkg::STAT_DONE_BIT]    = done_q;
      status_word[dbfa_pkg::STAT_REFUSED_BIT] = refused_q;
   end

   wire [31:0] rd_mux = (reg_addr == dbfa_pkg::REG_ADDR)   ? addr_q :
                        (reg_addr == dbfa_pkg::REG_WDATA)  ? wdata_q :
                        (reg_addr == dbfa_pkg::REG_CMD)    ? cmd_q :
                        (reg_addr == dbfa_pkg::REG_STATUS) ? status_word :
                        (reg_addr == dbfa_pkg::REG_RDATA)  ? rdata_q : 32'h0;

   // command port; read data stands one cycle after the strobe
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         addr_q    <= '0;
         wdata_q   <= '0;
         cmd_q     <= '0;
         reg_rdata <= '0;
      end
      else
      begin
         if (reg_wr && reg_addr == dbfa_pkg::REG_ADDR)
            addr_q <= reg_wdata;
         if (reg_wr && reg_addr == dbfa_pkg::REG_WDATA)
            wdata_q <= reg_wdata;
         if (cmd_wr)
            cmd_q <= reg_wdata;
         if (reg_rd)
            reg_rdata <= rd_mux;
      end
   end

   // refresh timer; a new request wins over the service that clears it
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ref_cnt_q  <= '0;
         ref_pend_q <= 1'b0;
      end
      else
      begin
         ref_cnt_q  <= ref_hit ? '0 : ref_cnt_q + 1'b1;
         ref_pend_q <= ref_hit || (ref_pend_q && !ref_go);
      end
   end

   // bus sequencer: row, column, cas hold, precharge; refresh is cas before ras only
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q         <= dbfa_pkg::H_IDLE;
         start_q         <= 1'b0;
         done_q          <= 1'b0;
         refused_q       <= 1'b0;
         last_flash_wr_q <= 1'b0;
         rdata_q         <= '0;
         cnt_q           <= '0;
         ras_n_q         <= 1'b1;
         cas_n_q         <= '1;
         we_n_q          <= 1'b1;
         addr_bus_q      <= '0;
         wdata_bus_q     <= '0;
         cpu_q           <= 1'b0;
      end
      else
      begin
         case (state_q)
            dbfa_pkg::H_IDLE:
            begin
               if (ref_go)
               begin
                  cas_n_q <= '0;
                  state_q <= dbfa_pkg::H_RFC;
               end
               else if (start_q)
               begin
                  start_q <= 1'b0;
                  if (!in_flash)
                  begin
                     last_flash_wr_q <= 1'b0;
                     state_q         <= dbfa_pkg::H_HOLD;
                  end
                  else if (guard_hit)
                  begin
                     refused_q <= 1'b1;
                     done_q    <= 1'b1;
                  end
                  else
                  begin
                     last_flash_wr_q <= is_write;
                     addr_bus_q      <= row_addr;
                     ras_n_q         <= 1'b0;
                     state_q         <= dbfa_pkg::H_ROW;
                  end
               end
            end
            dbfa_pkg::H_ROW:
            begin
               addr_bus_q  <= col_addr;
               cas_n_q     <= ~be;
               we_n_q      <= !is_write;
               wdata_bus_q <= wdata_q;
               cpu_q       <= !cmd_q[dbfa_pkg::CMD_MASTER_BIT];
               cnt_q       <= '0;
               state_q     <= dbfa_pkg::H_COL;
            end
            dbfa_pkg::H_COL:
            begin
               cnt_q <= cnt_q + 1'b1;
               // cas is held past the flash access time, so edo data is settled here
               if (hold_end)
               begin
                  rdata_q <= dram.rdata;
                  cas_n_q <= '1;
                  ras_n_q <= 1'b1;
                  we_n_q  <= 1'b1;
                  cpu_q   <= 1'b0;
                  done_q  <= 1'b1;
                  cnt_q   <= '0;
                  state_q <= dbfa_pkg::H_PRE;
               end
            end
            dbfa_pkg::H_HOLD:
            begin
               // other dram banks are not modelled; the access only serves as a fence
               rdata_q <= '0;
               done_q  <= 1'b1;
               state_q <= dbfa_pkg::H_IDLE;
            end
            dbfa_pkg::H_PRE:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (pre_end)
                  state_q <= dbfa_pkg::H_IDLE;
            end
            dbfa_pkg::H_RFC:
            begin
               ras_n_q <= 1'b0;
               cnt_q   <= '0;
               state_q <= dbfa_pkg::H_RFR;
            end
            dbfa_pkg::H_RFR:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (rfr_end)
               begin
                  ras_n_q <= 1'b1;
                  cas_n_q <= '1;
                  cnt_q   <= '0;
                  state_q <= dbfa_pkg::H_PRE;
               end
            end
            default:
            begin
               state_q <= dbfa_pkg::H_IDLE;
            end
         endcase
         // a new command clears the old outcome
         if (cmd_wr)
         begin
            start_q   <= 1'b1;
            done_q    <= 1'b0;
            refused_q <= 1'b0;
         end
      end
   end

endmodule : dbfa_ctrl
`default_nettype wire

/* include/dbfa_if.sv */
`timescale 1ns/100ps
`default_nettype none
// dram bus between the controller and the flash adapter
interface dbfa_if;
   logic                                ras_n;
   logic [dbfa_pkg::LANES-1:0]          cas_n;
   logic                                we_n;
   logic [dbfa_pkg::ROW_BITS-1:0]       addr;
   logic [dbfa_pkg::DATA_BITS-1:0]      wdata;
   logic                                cpu_cycle;
   logic [dbfa_pkg::DATA_BITS-1:0]      rdata;
   logic                                rdata_oe_n;

   modport ctrl (
      output ras_n,
      output cas_n,
      output we_n,
      output addr,
      output wdata,
      output cpu_cycle,
      input  rdata,
      input  rdata_oe_n
   );

   modport adapter (
      input  ras_n,
      input  cas_n,
      input  we_n,
      input  addr,
      input  wdata,
      input  cpu_cycle,
      output rdata,
      output rdata_oe_n
   );
endinterface : dbfa_if
`default_nettype wire

/* include/dbfa_pkg.sv */
package dbfa_pkg;

   // dram-side geometry of the flash bank
   localparam int ROW_BITS        = 11;
   localparam int COL_BITS        = 10;
   localparam int LANES           = 4;
   localparam int DATA_BITS       = 32;
   localparam int BANK_SEL_BIT    = 8;   // row bit that carries the bank select
   localparam int BANK_CPU_BIT    = 22;  // cpu address bit used as flash_bank_select_bit
   localparam int DWORD_CPU_BIT   = 2;   // dword_address_bit, lands on flash a0
   localparam int FLASH_ADDR_BITS = ROW_BITS - 1 + COL_BITS;

   // default flash bank bases behind 48 mbyte of dram
   localparam logic [31:0] FLASH_BANK0_BASE = 32'h0300_0000;
   localparam logic [31:0] FLASH_BANK1_BASE = 32'h0340_0000;
   localparam logic [31:0] FLASH_SPACE_SIZE = 32'h0080_0000;

   // timing, figures in ns, counts in 5 ns cycles
   localparam int CLK_PERIOD_PS    = 5000;
   localparam int FLASH_ACCESS_NS  = 70;
   localparam int FLASH_WE_NS      = 35;
   localparam int RAS_PRECHARGE_NS = 40;
   localparam int REF_RAS_NS       = 60;
   localparam int REFRESH_NS       = 15600;
   localparam int FLASH_ACC_CYC    = (FLASH_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FLASH_WE_CYC     = (FLASH_WE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PRECHARGE_CYC    = (RAS_PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int REF_RAS_CYC      = (REF_RAS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int REFRESH_CYC      = (REFRESH_NS * 1000) / CLK_PERIOD_PS;
   localparam int CAS_HOLD_CYC     = FLASH_ACC_CYC + 3;
   localparam int CNT_W            = 8;
   localparam int REF_W            = 12;

   // controller command port map
   localparam logic [4:0] REG_ADDR   = 5'h00;
   localparam logic [4:0] REG_WDATA  = 5'h04;
   localparam logic [4:0] REG_CMD    = 5'h08;
   localparam logic [4:0] REG_STATUS = 5'h0c;
   localparam logic [4:0] REG_RDATA  = 5'h10;
   localparam int CMD_WRITE_BIT  = 0;
   localparam int CMD_MASTER_BIT = 1;
   localparam int CMD_BE_LSB     = 4;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_DONE_BIT  = 1;
   localparam int STAT_REFUSED_BIT = 2;

   typedef enum logic [1:0] {
      A_IDLE  = 2'b00,
      A_READ  = 2'b01,
      A_WRITE = 2'b10,
      A_HOLD  = 2'b11
   } dbfa_astate_e;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_ROW  = 3'b001,
      H_COL  = 3'b010,
      H_HOLD = 3'b011,
      H_PRE  = 3'b100,
      H_RFC  = 3'b101,
      H_RFR  = 3'b110
   } dbfa_hstate_e;

   // row address for an offset inside the flash space
   function automatic logic [ROW_BITS-1:0] dbfa_row_of(input logic [31:0] off);
      logic [FLASH_ADDR_BITS-1:0] fa;
      fa = off[DWORD_CPU_BIT +: FLASH_ADDR_BITS];
      return {fa[FLASH_ADDR_BITS-1:COL_BITS+BANK_SEL_BIT], off[BANK_CPU_BIT],
              fa[COL_BITS+BANK_SEL_BIT-1:COL_BITS]};
   endfunction : dbfa_row_of

   // byte-mode flash address from row and column, bank bit removed
   function automatic logic [FLASH_ADDR_BITS-1:0] dbfa_flash_of(input logic [ROW_BITS-1:0] row,
                                                                 input logic [COL_BITS-1:0] col);
      return {row[ROW_BITS-1:BANK_SEL_BIT+1], row[BANK_SEL_BIT-1:0], col};
   endfunction : dbfa_flash_of

endpackage : dbfa_pkg

/* testbench/dbfa_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module dbfa_bench;
   localparam logic [31:0] RD = 32'h0000_00f0;
   localparam logic [31:0] WR = 32'h0000_00f1;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic [4:0]  reg_addr = 5'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata, dq_in, dq_out, pat, rd, wr_data;
   logic [19:0] fa, wr_addr;
   logic [1:0]  ce_n, wr_ce;
   logic        oe_n, we_n;
   logic [31:0] offs [6] = '{32'h0, 32'h4, 32'h2aa8, 32'h3ffffc, 32'h400000, 32'h7ffffc};
   int          error_cnt = 0;
   int          checked = 0;
   int          we_cnt = 0;
   int          act_cnt = 0;
   int          n;

   dbfa_if dram ();
   dbfa_ctrl #(.REFRESH_CYC(200)) u_dbfa_ctrl (.clock(clock), .reset_n(reset_n), .dram(dram),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   dbfa_adapter u_dbfa_adapter (.clock(clock), .reset_n(reset_n), .dram(dram), .flash_ce_n(ce_n),
      .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fa), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
      .flash_dq_oe_n(), .access_ignored());
   dbfa_monitor u_dbfa_monitor (.clock(clock), .reset_n(reset_n), .ras_n(dram.ras_n), .cas_n(dram.cas_n),
      .we_n(dram.we_n), .cpu_cycle(dram.cpu_cycle), .rdata_oe_n(dram.rdata_oe_n));

   always #2.5 clock = ~clock;
   // flash model: bank tag plus device address; inverted when not output-enabled
   assign pat = {ce_n[0] ? 4'hb : 4'ha, 8'h3c, fa};
   assign dq_in = oe_n ? ~pat : pat;
   // flash command capture while the write strobe is low; chip enable drops with the strobe
   always @(posedge clock)
      if (reset_n && we_n === 1'b0)
      begin
         wr_addr <= fa;
         wr_data <= dq_out;
         wr_ce <= ce_n;
      end
   always @(posedge we_n)
      if (reset_n)
         we_cnt <= we_cnt + 1;
   always @(posedge clock)
      if (reset_n && ce_n !== 2'b11)
         act_cnt <= act_cnt + 1;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask : reg_read

   // issue one command and poll busy under a bound
   task automatic run(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
      logic [31:0] s;
      reg_write(dbfa_pkg::REG_ADDR, a);
      reg_write(dbfa_pkg::REG_WDATA, d);
      reg_write(dbfa_pkg::REG_CMD, c);
      s = 32'h1;
      for (int i = 0; i < 300 && s[dbfa_pkg::STAT_BUSY_BIT] !== 1'b0; i++)
         reg_read(dbfa_pkg::REG_STATUS, s);
      if (s[dbfa_pkg::STAT_BUSY_BIT] !== 1'b0)
         chk(32'h1, 32'h0, "command hung");
   endtask : run

   // flash write fenced by other-bank reads, as software must do it
   task automatic wflash(input logic [31:0] a, input logic [31:0] d, input logic [1:0] ce, input logic [19:0] f);
      n = we_cnt;
      run(32'h0, 32'h0, RD);
      run(a, d, WR);
      run(32'h0, 32'h0, RD);
      chk(32'(we_cnt - n), 32'h1, "write strobes");
      chk({12'h0, wr_addr}, {12'h0, f}, "write address");
      chk(wr_data, d, "write data");
      chk({30'h0, wr_ce}, {30'h0, ce}, "write bank");
   endtask : wflash

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test

   initial
   begin
      #100000;
      error_cnt++;
      stop_test();
   end

   initial
   begin
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      // back-to-back reads over both banks and their edges
      foreach (offs[i])
      begin
         run(dbfa_pkg::FLASH_BANK0_BASE + offs[i], 32'h0, RD);
         reg_read(dbfa_pkg::REG_RDATA, rd);
         chk(rd, {offs[i][22] ? 4'hb : 4'ha, 8'h3c, offs[i][21:2]}, "read");
      end
      $display("test reads done");
      wflash(32'h0300_2aa8, 32'h0000_00aa, 2'b10, 20'haaa);
      wflash(32'h0340_1554, 32'h0000_0055, 2'b01, 20'h555);
      $display("test writes done");
      // a second write with no fence must not reach the flash
      n = we_cnt;
      run(dbfa_pkg::FLASH_BANK0_BASE, 32'h0000_00f0, WR);
      run(dbfa_pkg::FLASH_BANK0_BASE, 32'h0000_00f0, WR);
      run(32'h0, 32'h0, RD);
      chk(32'(we_cnt - n), 32'h1, "unfenced write");
      $display("test write guard done");
      n = act_cnt;
      run(dbfa_pkg::FLASH_BANK0_BASE, 32'h0, 32'h0000_00f2);
      chk(32'(act_cnt - n), 32'h0, "master access");
      run(dbfa_pkg::FLASH_BANK0_BASE, 32'h0, 32'h0000_0030);
      chk(32'(act_cnt - n), 32'h0, "partial access");
      $display("test refusals done");
      stop_test();
   end
endmodule : dbfa_bench
`default_nettype wire

/* testbench/dbfa_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// watches the dram-side bus between the controller and the adapter
module dbfa_monitor (
   input wire logic                       clock,
   input wire logic                       reset_n,
   input wire logic                       ras_n,
   input wire logic [dbfa_pkg::LANES-1:0] cas_n,
   input wire logic                       we_n,
   input wire logic                       cpu_cycle,
   input wire logic                       rdata_oe_n
);
   default clocking mon_cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   // read drive only inside a full-width cpu read with the row open
   AST_OE_FULL_CAS: assert property (!rdata_oe_n |-> (cas_n == 4'h0 || $past(cas_n) == 4'h0))
      else $error("read drive without full cas");
   AST_OE_ONLY_READ: assert property (!rdata_oe_n |-> we_n)
      else $error("read drive during a write");
   AST_OE_ONLY_CPU: assert property (!rdata_oe_n |-> (cpu_cycle || $past(cpu_cycle)))
      else $error("read drive for a bus master");
   AST_OE_IN_ROW: assert property (!rdata_oe_n |-> (!ras_n || !$past(ras_n)))
      else $error("read drive with row closed");
   AST_PARTIAL_IGNORED: assert property ((cas_n != 4'h0 && cas_n != 4'hf) |-> rdata_oe_n)
      else $error("partial access answered");
   // refresh is cas before ras only, and must never look like a read
   AST_REFRESH_QUIET: assert property (($fell(ras_n) && cas_n == 4'h0) |-> rdata_oe_n [*3])
      else $error("read drive during refresh");
   AST_RAS_FALL_CLEAN: assert property ($fell(ras_n) |-> (cas_n == 4'hf || cas_n == 4'h0))
      else $error("row opened with split cas");
   AST_OE_RELEASE: assert property ($rose(ras_n) |-> ##[0:3] rdata_oe_n)
      else $error("read drive held after row close");
   AST_WRITE_NO_DRIVE: assert property ((!we_n && cas_n == 4'h0) |=> rdata_oe_n [*2])
      else $error("write cycle drove read data");

   cover property (!rdata_oe_n);
   cover property (!we_n && cas_n == 4'h0);
   cover property ($fell(ras_n) && cas_n == 4'h0);
endmodule : dbfa_monitor
`default_nettype wire
